// ===== src/ddr_cmd_decode.sv
// DRAM command, address, termination and data-lane decoder with a Wishbone status port.
// Functional notes
// - Bank bits with activate, read, write or precharge pick the bank.
// - Bank bits during mode register set pick the mode register.
// - Read or write with auto precharge high closes the bank afterwards.
// - Precharge with auto precharge low closes one bank, high closes all.
// - Single-bank precharge acts only on the bank given on the bank bits.
// - Address is the row on activate, start column on read or write.
// - Address is the opcode stored by a mode register set.
// - Burst chop bit high gives a full burst, low a chopped burst.
// - Termination turns on when the enable input is registered high.
// - Termination covers data, strobes, mask; strobe pins only in strobe mode.
// - Enable input ignored while both mode registers disable termination.
// - Reset input is active low and acts without the clock.
// - Leveling feedback goes out on the prime bit of each lane.
// - Read strobe is edge aligned with data; write strobe is centred.
// - Every command is ignored while chip select is registered high.
// - A write beat sampled with its mask high is discarded.
// - Burst chop bit honoured only when on-the-fly bursts are enabled.
//
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
module ddr_cmd_decode #(
  parameter int LANES = 2,
  parameter int DQ_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ddr_cmd_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ddr_cmd_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic [ddr_cmd_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ck_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [ddr_cmd_pkg::BANK_W-1:0] bank_address_bits_i,
  input wire logic [ddr_cmd_pkg::ADDR_W-1:0] address_bus_i,
  input wire logic termination_enable_input_i,
  output logic cmd_valid_o,
  output ddr_cmd_pkg::cmd_t cmd_kind_o,
  output logic [ddr_cmd_pkg::BANK_W-1:0] cmd_bank_o,
  output logic [ddr_cmd_pkg::ADDR_W-1:0] cmd_row_o,
  output logic [ddr_cmd_pkg::ADDR_W-1:0] cmd_col_o,
  output logic cmd_auto_pre_o,
  output logic cmd_burst_full_o,
  output logic [ddr_cmd_pkg::NUM_BANKS-1:0] pre_bank_mask_o,
  output logic [ddr_cmd_pkg::NUM_BANKS-1:0] open_banks_o,
  output logic term_dq_o,
  output logic term_dqs_o,
  output logic term_mask_o,
  output logic term_strobe_o,
  input wire logic wr_beat_i,
  input wire logic [LANES-1:0] wr_mask_i,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] wr_data_o,
  output logic [LANES-1:0] wr_lane_en_o,
  input wire logic rd_valid_i,
  input wire logic [DQ_W-1:0] rd_data_i,
  output logic [DQ_W-1:0] dq_o,
  output logic [DQ_W-1:0] dq_oe_o,
  output logic dqs_o,
  output logic dqs_oe_o,
  input wire logic dqs_i
);
  import ddr_cmd_pkg::*;

  localparam int SNAP_W = STAT_W + MR_COUNT * ADDR_W;

  // Elaboration check on the lane layout.
  if (LANES < 1 || LANES > 2 || DQ_W != LANES * BYTE_W)
  begin : g_check
    $error("unsupported lane layout");
  end

  logic wb_req;
  logic ctrl_wide_reg;
  logic [SNAP_W-1:0] snap_src;
  logic [SNAP_W-1:0] snap_dst;
  logic wide_meta_reg;
  logic wide_sync_reg;
  logic dqs_meta_reg;
  logic dqs_sync_reg;
  logic [2:0] pin_code;
  logic cmd_sel;
  logic is_act;
  logic is_read;
  logic is_write;
  logic is_rdwr;
  logic is_pre;
  logic is_modeset;
  logic [MR_IDX_W-1:0] mr_idx;
  logic [ADDR_W-1:0] mode_reg [MR_COUNT];
  logic [NUM_BANKS-1:0] open_mask_reg;
  logic [NUM_BANKS-1:0] bank_onehot;
  logic otf_en;
  logic burst_full;
  logic rtt_disabled;
  logic term_strobe_mode;
  logic wl_en;
  logic term_reg;
  logic term_strobe_reg;

  // Command word decode straight from the pins sampled on this edge.
  assign pin_code = {ras_n_i, cas_n_i, we_n_i};
  assign cmd_sel = !cs_n_i;
  assign is_act = cmd_sel && (pin_code == PIN_ACT);
  assign is_read = cmd_sel && (pin_code == PIN_READ);
  assign is_write = cmd_sel && (pin_code == PIN_WRITE);
  assign is_rdwr = is_read || is_write;
  assign is_pre = cmd_sel && (pin_code == PIN_PRE);
  assign is_modeset = cmd_sel && (pin_code == PIN_MODESET);
  assign mr_idx = bank_address_bits_i[MR_IDX_W-1:0];
  assign bank_onehot = NUM_BANKS'(1) << bank_address_bits_i;

  // Mode register fields that steer the decoder.
  assign otf_en = (mode_reg[0][BL_HI:BL_LO] == BL_OTF);
  assign term_strobe_mode = mode_reg[1][TERM_STROBE_BIT];
  assign wl_en = mode_reg[1][WL_BIT];
  assign rtt_disabled = !(mode_reg[1][RTT_NOM_B0] || mode_reg[1][RTT_NOM_B1]
                        || mode_reg[1][RTT_NOM_B2])
                        && (mode_reg[2][RTT_WR_HI:RTT_WR_LO] == RTT_WR_OFF);

  // chop only on-the-fly
  // Outside on-the-fly mode the programmed length decides and the chop bit is don't care.
  assign burst_full = otf_en ? address_bus_i[BC_BIT]
                             : (mode_reg[0][BL_HI:BL_LO] != BL_BC4);

  // asynchronous reset
  // Every link-side flop takes its reset value on a low reset input, with or without the clock.
  always_ff @(posedge ck_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cmd_valid_o <= 1'b0;
      cmd_kind_o <= CMD_NONE;
      cmd_bank_o <= '0;
      cmd_row_o <= '0;
      cmd_col_o <= '0;
      cmd_auto_pre_o <= 1'b0;
      cmd_burst_full_o <= 1'b1;
      pre_bank_mask_o <= '0;
    end
    else
    begin
      cmd_valid_o <= is_act || is_rdwr || is_pre || is_modeset;
      cmd_kind_o <= CMD_NONE;
      pre_bank_mask_o <= '0;
      if (is_act || is_rdwr || is_pre || is_modeset)
        cmd_bank_o <= bank_address_bits_i;
      if (is_act)
      begin
        cmd_kind_o <= CMD_ACT;
        cmd_row_o <= address_bus_i;
      end
      if (is_rdwr)
      begin
        cmd_kind_o <= is_read ? CMD_READ : CMD_WRITE;
        cmd_col_o <= address_bus_i;
        cmd_auto_pre_o <= address_bus_i[AP_BIT];
        cmd_burst_full_o <= burst_full;
      end
      if (is_pre)
      begin
        cmd_kind_o <= CMD_PRE;
        cmd_auto_pre_o <= address_bus_i[AP_BIT];
        pre_bank_mask_o <= address_bus_i[AP_BIT] ? '1 : bank_onehot;
      end
      if (is_modeset)
        cmd_kind_o <= CMD_MODESET;
    end
  end

  // opcode store
  // Mode registers come up cleared, which also leaves termination disabled.
  always_ff @(posedge ck_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < MR_COUNT; i++)
        mode_reg[i] <= MODE_RESET;
    end
    else if (is_modeset && !bank_address_bits_i[BANK_W-1])
      mode_reg[mr_idx] <= address_bus_i;
  end

  // close after access
  // The bank is marked closed at the command; the core times the real precharge.
  always_ff @(posedge ck_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      open_mask_reg <= '0;
    else if (is_act)
      open_mask_reg <= open_mask_reg | bank_onehot;
    else if (is_pre && address_bus_i[AP_BIT])
      open_mask_reg <= '0;
    else if (is_pre || (is_rdwr && address_bus_i[AP_BIT]))
      open_mask_reg <= open_mask_reg & ~bank_onehot;
  end

  assign open_banks_o = open_mask_reg;

  // The part width set by software and the leveling strobe both arrive from other timing.
  always_ff @(posedge ck_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wide_meta_reg <= CTRL_RESET;
      wide_sync_reg <= CTRL_RESET;
      dqs_meta_reg <= 1'b0;
      dqs_sync_reg <= 1'b0;
    end
    else
    begin
      wide_meta_reg <= ctrl_wide_reg;
      wide_sync_reg <= wide_meta_reg;
      dqs_meta_reg <= dqs_i;
      dqs_sync_reg <= dqs_meta_reg;
    end
  end

  always_ff @(posedge ck_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      term_reg <= 1'b0;
      term_strobe_reg <= 1'b0;
    end
    else
    begin
      term_reg <= termination_enable_input_i && !rtt_disabled;
      term_strobe_reg <= termination_enable_input_i && !rtt_disabled
                         && term_strobe_mode && !wide_sync_reg;
    end
  end

  // termination targets
  // One strobe flag stands for both strobe polarities.
  assign term_dq_o = term_reg;
  assign term_dqs_o = term_reg;
  assign term_mask_o = term_reg;
  assign term_strobe_o = term_strobe_reg;

  // edge aligned strobe
  // Strobe toggles on the same edge as read data; write centring is the controller's.
  always_ff @(posedge ck_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dqs_o <= 1'b0;
      dqs_oe_o <= 1'b0;
      wr_data_o <= '0;
    end
    else
    begin
      dqs_oe_o <= rd_valid_i;
      dqs_o <= rd_valid_i ? !dqs_o : 1'b0;
      wr_data_o <= dq_i;
    end
  end

  // Per-lane write enables and output drive; the high lane idles on a narrow part.
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    logic lane_on;
    logic lane_en_reg;
    logic [BYTE_W-1:0] lane_dq_reg;
    logic [BYTE_W-1:0] lane_oe_reg;
    assign lane_on = (l == 0) || wide_sync_reg;
    always_ff @(posedge ck_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        lane_en_reg <= 1'b0;
        lane_dq_reg <= '0;
        lane_oe_reg <= '0;
      end
      else
      begin
        lane_en_reg <= wr_beat_i && !wr_mask_i[l] && lane_on;
        if (rd_valid_i && lane_on)
        begin
          lane_dq_reg <= rd_data_i[l*BYTE_W +: BYTE_W];
          lane_oe_reg <= '1;
        end
        else if (wl_en && lane_on)
        begin
          lane_dq_reg <= BYTE_W'(dqs_sync_reg);
          lane_oe_reg <= BYTE_W'(1);
        end
        else
          lane_oe_reg <= '0;
      end
    end
    assign wr_lane_en_o[l] = lane_en_reg;
    assign dq_o[l*BYTE_W +: BYTE_W] = lane_dq_reg;
    assign dq_oe_o[l*BYTE_W +: BYTE_W] = lane_oe_reg;
  end

  // Snapshot of link-side state for software: mode registers above the status bits.
  assign snap_src = {mode_reg[3], mode_reg[2], mode_reg[1], mode_reg[0],
                     wl_en, otf_en, term_strobe_mode, term_reg, open_mask_reg};

  word_crossing #(
    .WIDTH(SNAP_W)
  ) u_snap (
    .src_clk_i(ck_i),
    .src_rst_n_i(reset_n_i),
    .src_data_i(snap_src),
    .dst_clk_i(clk_i),
    .dst_rst_i(rst_i),
    .dst_data_o(snap_dst)
  );

  // Wishbone slave answers every access one cycle after it is seen.
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  // Control write; only the low byte lane carries a field.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_wide_reg <= CTRL_RESET;
    else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFS)
      ctrl_wide_reg <= wb_dat_i[CTRL_WIDE_BIT];
  end

  // Read data; unmapped offsets read zero and are still acknowledged.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= '0;
    else if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        CTRL_OFS: wb_dat_o <= WB_DAT_W'(ctrl_wide_reg);
        STATUS_OFS: wb_dat_o <= WB_DAT_W'(snap_dst[STAT_W-1:0]);
        MODE01_OFS: wb_dat_o <= snap_dst[STAT_W +: WB_DAT_W];
        MODE23_OFS: wb_dat_o <= snap_dst[STAT_W+WB_DAT_W +: WB_DAT_W];
        default: wb_dat_o <= '0;
      endcase
    end
  end

  cs_ignore_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    cs_n_i |=> !cmd_valid_o && cmd_kind_o == CMD_NONE)
    else $error("command taken while chip select high");

  bank_select_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    (is_act || is_rdwr || is_pre) |=> cmd_valid_o && cmd_bank_o == $past(bank_address_bits_i))
    else $error("wrong bank on command");

  mode_write_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    is_modeset && !bank_address_bits_i[BANK_W-1]
    |=> mode_reg[$past(mr_idx)] == $past(address_bus_i))
    else $error("opcode not stored in selected mode register");

  row_col_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    is_act |=> cmd_kind_o == CMD_ACT && cmd_row_o == $past(address_bus_i))
    else $error("row address not taken");

  col_take_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    is_rdwr |=> cmd_col_o == $past(address_bus_i) && cmd_kind_o != CMD_ACT)
    else $error("column address not taken");

  auto_pre_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    is_rdwr && address_bus_i[AP_BIT] |=> cmd_auto_pre_o && !(|(open_mask_reg & $past(bank_onehot))))
    else $error("bank left open after auto precharge");

  pre_all_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    is_pre && address_bus_i[AP_BIT] |=> open_mask_reg == '0 && pre_bank_mask_o == '1)
    else $error("precharge all missed a bank");

  pre_one_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    is_pre && !address_bus_i[AP_BIT] |=> pre_bank_mask_o == $past(bank_onehot)
    && (open_mask_reg | $past(bank_onehot)) == ($past(open_mask_reg) | $past(bank_onehot)))
    else $error("single precharge touched another bank");

  chop_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    is_rdwr && otf_en |=> cmd_burst_full_o == $past(address_bus_i[BC_BIT]))
    else $error("burst chop bit not followed");

  chop_fixed_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    is_rdwr && !otf_en && mode_reg[0][BL_HI:BL_LO] != BL_BC4 |=> cmd_burst_full_o)
    else $error("chop honoured outside on-the-fly mode");

  term_on_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    termination_enable_input_i && !rtt_disabled |=> term_dq_o && term_dqs_o && term_mask_o)
    else $error("termination not enabled");

  term_ignore_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    rtt_disabled |=> !term_dq_o && !term_strobe_o)
    else $error("termination on while disabled");

  strobe_mode_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    !term_strobe_mode |=> !term_strobe_o)
    else $error("strobe pins terminated outside strobe mode");

  mask_drop_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    wr_beat_i && wr_mask_i[0] |=> !wr_lane_en_o[0])
    else $error("masked beat written");

  read_strobe_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    rd_valid_i |=> dqs_oe_o && dq_oe_o[0] && dqs_o != $past(dqs_o))
    else $error("read strobe not aligned with data");

  level_fb_a: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    wl_en && !rd_valid_i |=> dq_oe_o[0] && !dq_oe_o[1] && dq_o[0] == $past(dqs_sync_reg))
    else $error("leveling feedback not on prime bit");

  reset_async_a: assert property (@(posedge ck_i)
    !reset_n_i |-> !cmd_valid_o && open_mask_reg == '0 && !term_dq_o)
    else $error("state not cleared under reset");

  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");

  act_seen_c: cover property (@(posedge ck_i) disable iff (!reset_n_i) is_act ##1 is_rdwr);
  pre_all_c: cover property (@(posedge ck_i) disable iff (!reset_n_i)
    is_pre && address_bus_i[AP_BIT]);
  bus_read_c: cover property (@(posedge clk_i) disable iff (rst_i) wb_req && !wb_we_i);
endmodule

// ===== pkg/ddr_cmd_pkg.sv
// Shared constants and types for the DRAM command and address decoder.
package ddr_cmd_pkg;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 16;
  localparam int NUM_BANKS = 8;
  localparam int BYTE_W = 8;
  localparam int MR_COUNT = 4;
  localparam int MR_IDX_W = 2;
  localparam int STAT_W = 12;
  // Address bit roles.
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  // Mode register fields.
  localparam int TERM_STROBE_BIT = 11;
  localparam int WL_BIT = 7;
  localparam int RTT_NOM_B0 = 2;
  localparam int RTT_NOM_B1 = 6;
  localparam int RTT_NOM_B2 = 9;
  localparam int RTT_WR_LO = 9;
  localparam int RTT_WR_HI = 10;
  localparam int BL_LO = 0;
  localparam int BL_HI = 1;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_BC4 = 2'h2;
  localparam logic [1:0] RTT_WR_OFF = 2'h0;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  // Command codes on {row strobe, column strobe, write enable}, all active low.
  localparam logic [2:0] PIN_MODESET = 3'h0;
  localparam logic [2:0] PIN_PRE = 3'h2;
  localparam logic [2:0] PIN_ACT = 3'h3;
  localparam logic [2:0] PIN_WRITE = 3'h4;
  localparam logic [2:0] PIN_READ = 3'h5;
  // Wishbone register map.
  localparam int WB_ADR_W = 4;
  localparam int WB_DAT_W = 32;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] MODE01_OFS = 4'h8;
  localparam logic [3:0] MODE23_OFS = 4'hC;
  localparam int CTRL_WIDE_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int ST_TERM_BIT = 8;
  localparam int ST_TERM_STROBE_BIT = 9;
  localparam int ST_OTF_BIT = 10;
  localparam int ST_WL_BIT = 11;
  typedef enum logic [5:0] {
    CMD_NONE = 6'h01,
    CMD_ACT = 6'h02,
    CMD_READ = 6'h04,
    CMD_WRITE = 6'h08,
    CMD_PRE = 6'h10,
    CMD_MODESET = 6'h20
  } cmd_t;
endpackage

// ===== src/word_crossing.sv
// Handshake crossing that carries a snapshot word from the link domain to the bus domain.
`timescale 1ns/1ns
module word_crossing #(
  parameter int WIDTH = 8
) (
  input wire logic src_clk_i,
  input wire logic src_rst_n_i,
  input wire logic [WIDTH-1:0] src_data_i,
  input wire logic dst_clk_i,
  input wire logic dst_rst_i,
  output logic [WIDTH-1:0] dst_data_o
);
  logic [WIDTH-1:0] hold_reg;
  logic req_reg;
  logic ack_reg;
  logic [1:0] req_sync_reg;
  logic [1:0] ack_sync_reg;

  // Request toggle enters the link domain through two flip-flops.
  always_ff @(posedge src_clk_i or negedge src_rst_n_i)
  begin
    if (!src_rst_n_i)
      req_sync_reg <= 2'h0;
    else
      req_sync_reg <= {req_sync_reg[0], req_reg};
  end

  // The hold word changes only on a new request, so it is still while the bus side loads it.
  always_ff @(posedge src_clk_i or negedge src_rst_n_i)
  begin
    if (!src_rst_n_i)
    begin
      hold_reg <= '0;
      ack_reg <= 1'b0;
    end
    else if (req_sync_reg[1] != ack_reg)
    begin
      hold_reg <= src_data_i;
      ack_reg <= req_sync_reg[1];
    end
  end

  // Acknowledge toggle enters the bus domain through two flip-flops.
  always_ff @(posedge dst_clk_i)
  begin
    if (dst_rst_i)
      ack_sync_reg <= 2'h0;
    else
      ack_sync_reg <= {ack_sync_reg[0], ack_reg};
  end

  // A stopped link clock simply leaves the last snapshot in place.
  always_ff @(posedge dst_clk_i)
  begin
    if (dst_rst_i)
    begin
      req_reg <= 1'b0;
      dst_data_o <= '0;
    end
    else if (ack_sync_reg[1] == req_reg)
    begin
      dst_data_o <= hold_reg;
      req_reg <= !req_reg;
    end
  end
endmodule

// ===== testbench/ctrl_model.sv
// Memory controller model driving command, termination and reset pins.
`timescale 1ns/1ns
module ctrl_model (
  input wire logic ck_i,
  output logic reset_n_o,
  output logic cs_n_o,
  output logic [2:0] code_o,
  output logic [2:0] bank_o,
  output logic [15:0] addr_o,
  output logic term_en_o
);
  // Pins start deselected; reset falls a moment later so every flop sees a clean edge.
  initial
  begin
    reset_n_o = 1'b1;
    cs_n_o = 1'b1;
    code_o = 3'h7;
    bank_o = 3'h0;
    addr_o = 16'h0000;
    term_en_o = 1'b0;
    #2;
    reset_n_o = 1'b0;
  end

  // whole command word
  // Idle pins carry the inverted bank and address with an all-high code, so stale values never pass for fresh ones.
  task automatic issue(input logic [2:0] code, input logic [2:0] bank,
                       input logic [15:0] addr, input logic sel_n);
    @(posedge ck_i);
    cs_n_o <= sel_n;
    code_o <= code;
    bank_o <= bank;
    addr_o <= addr;
    @(posedge ck_i);
    cs_n_o <= 1'b1;
    code_o <= 3'h7;
    bank_o <= ~bank;
    addr_o <= ~addr;
    // Return just after the sampling edge, while the one-cycle outputs still stand.
    #1;
  endtask

  // reset level driven
  // The level moves mid-cycle on purpose, to show the reset needs no clock.
  task automatic hold_reset(input logic level);
    @(posedge ck_i);
    #20;
    reset_n_o = level;
  endtask

  // Termination enable changes just after a clock edge.
  task automatic set_term_en(input logic level);
    @(posedge ck_i);
    term_en_o <= level;
  endtask
endmodule

// ===== testbench/tb.sv
// Self-checking testbench for the DRAM command decoder.
`timescale 1ns/1ns
module tb;
  import ddr_cmd_pkg::*;
  logic clk_i = 1'b0;
  logic ck = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic reset_n, cs_n, term_en;
  logic [2:0] code, ba;
  logic [15:0] addr;
  logic beat = 1'b0;
  logic [1:0] mask = 2'h0;
  logic [15:0] dqi = 16'h0;
  logic rdv = 1'b0;
  logic [15:0] rdd = 16'h0;
  logic dqs_in = 1'b0;
  logic valid, ap, bf, tdq, tdst, tmask, tstr, dqs, dqsoe;
  cmd_t kind;
  logic [2:0] bank;
  logic [15:0] row, col, wdo, dqo, dqoe;
  logic [7:0] pmask, open;
  logic [1:0] len;
  logic [31:0] q;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Bus clock 8 ns; link clock 80 ns, offset so that its edges never meet the bus clock's.
  always #4 clk_i = ~clk_i;
  initial
  begin
    #3;
    forever #40 ck = ~ck;
  end

  ddr_cmd_decode u_ddr_cmd_decode (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ck_i(ck), .reset_n_i(reset_n), .cs_n_i(cs_n),
    .ras_n_i(code[2]), .cas_n_i(code[1]), .we_n_i(code[0]), .bank_address_bits_i(ba),
    .address_bus_i(addr), .termination_enable_input_i(term_en), .cmd_valid_o(valid),
    .cmd_kind_o(kind), .cmd_bank_o(bank), .cmd_row_o(row), .cmd_col_o(col),
    .cmd_auto_pre_o(ap), .cmd_burst_full_o(bf), .pre_bank_mask_o(pmask),
    .open_banks_o(open), .term_dq_o(tdq), .term_dqs_o(tdst), .term_mask_o(tmask),
    .term_strobe_o(tstr), .wr_beat_i(beat), .wr_mask_i(mask), .dq_i(dqi),
    .wr_data_o(wdo), .wr_lane_en_o(len), .rd_valid_i(rdv), .rd_data_i(rdd),
    .dq_o(dqo), .dq_oe_o(dqoe), .dqs_o(dqs), .dqs_oe_o(dqsoe), .dqs_i(dqs_in));

  ctrl_model u_ctrl_model (.ck_i(ck), .reset_n_o(reset_n), .cs_n_o(cs_n), .code_o(code),
    .bank_o(ba), .addr_o(addr), .term_en_o(term_en));

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compares one zero-extended value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone cycle; read data is taken at the edge that sees ack.
  // The wait has no limit of its own; the bench timeout ends a hang.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a);
    u_ctrl_model.issue(c, b, a, 1'b0);
  endtask

  task automatic wait_ck(input int n);
    repeat (n) @(posedge ck);
    #1;
  endtask

  // A hang ends the run as a failure.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  // Main sequence of scenarios.
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    u_ctrl_model.hold_reset(1'b1);
    cmd(PIN_ACT, 3'h5, 16'h1234);
    chk({valid, kind, bank, row}, {1'b1, CMD_ACT, 3'h5, 16'h1234});
    u_ctrl_model.issue(PIN_ACT, 3'h2, 16'h0055, 1'b1);
    chk({valid, open}, {1'b0, 8'h20});
    cmd(PIN_ACT, 3'h2, 16'h0055);
    chk(open, 8'h24);
    cmd(PIN_READ, 3'h5, 16'h0400);
    chk({kind, bank, col, ap, bf}, {CMD_READ, 3'h5, 16'h0400, 2'b11});
    chk(open, 8'h04);
    cmd(PIN_MODESET, 3'h0, 16'h0001);
    chk({kind, bank}, {CMD_MODESET, 3'h0});
    cmd(PIN_WRITE, 3'h2, 16'h0008);
    chk({kind, col, ap, bf, open}, {CMD_WRITE, 16'h0008, 2'b00, 8'h04});
    cmd(PIN_WRITE, 3'h2, 16'h1008);
    chk(bf, 1'b1);
    // Fixed chopped length ignores the chop bit; a select with bit two high writes nothing.
    cmd(PIN_MODESET, 3'h0, 16'h0002);
    cmd(PIN_READ, 3'h2, 16'h1000);
    chk({kind, bf}, {CMD_READ, 1'b0});
    cmd(PIN_MODESET, 3'h0, 16'h0001);
    cmd(PIN_MODESET, 3'h4, 16'h0002);
    chk({valid, kind}, {1'b1, CMD_MODESET});
    cmd(PIN_PRE, 3'h2, 16'h0000);
    chk({pmask, open}, {8'h04, 8'h00});
    cmd(PIN_PRE, 3'h0, 16'h0400);
    chk(pmask, 8'hFF);
    u_ctrl_model.set_term_en(1'b1);
    wait_ck(3);
    chk({tdq, tdst, tmask, tstr}, 4'h0);
    cmd(PIN_MODESET, 3'h1, 16'h0804);
    wait_ck(4);
    chk({tdq, tdst, tmask, tstr}, 4'hF);
    wb(1'b0, MODE01_OFS, 32'h0);
    chk(q, 32'h08040001);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk(q, 32'h00000700);
    wb(1'b1, CTRL_OFS, 32'h1);
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(q, 32'h1);
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    wait_ck(4);
    chk({tdq, tstr}, 2'b10);
    // One write beat with lane one masked, alongside one read beat.
    @(posedge ck);
    beat <= 1'b1;
    mask <= 2'b10;
    dqi <= 16'hA55A;
    rdv <= 1'b1;
    rdd <= 16'h3CC3;
    @(posedge ck);
    beat <= 1'b0;
    rdv <= 1'b0;
    dqs_in <= 1'b1;
    #1;
    chk({wdo, len}, {16'hA55A, 2'b01});
    chk({dqo, dqoe}, {16'h3CC3, 16'hFFFF});
    chk({dqsoe, dqs}, 2'b11);
    cmd(PIN_MODESET, 3'h1, 16'h0884);
    wait_ck(5);
    chk({dqoe, dqo}, 32'h01010101);
    cmd(PIN_ACT, 3'h3, 16'h0011);
    u_ctrl_model.hold_reset(1'b0);
    #1;
    chk({open, tdq, bf}, {8'h00, 2'b01});
    u_ctrl_model.hold_reset(1'b1);
    close_out();
  end
endmodule
